// >>> verilog/video_fifo_map.svh
// Constants for the video FIFO and its DMA request path
`ifndef VIDEO_FIFO_MAP_SVH
`define VIDEO_FIFO_MAP_SVH

// Register select, upper nibble of the select byte
`define SEL_MSB         31
`define SEL_LSB         28
`define SEL_CONTROL     4'he
`define SEL_DATA_CTRL   4'hf

// Control register preload field
`define PRELOAD_MSB     10
`define PRELOAD_LSB     8
`define PRELOAD_RESET   3'h1

// Data control register fields
`define HWIDTH_MSB      10
`define HWIDTH_LSB      0
`define HWIDTH_RESET    11'h000
`define HDIS_BIT        13
`define DTEST_MSB       19
`define DTEST_LSB       16

// Write window for the macrocell registers
`define REG_WIN_BASE    32'h03400000
`define REG_WIN_LIMIT   32'h034fffff

// Words per quad-word burst
`define QUAD_WORDS      4

`endif

// >>> verilog/video_fifo_pkg.sv
// Types shared by the video FIFO device and the DMA arbiter
package video_fifo_pkg;

	// Device request phases
	typedef enum logic [1:0] {
		flush_st,
		preload_st,
		run_st
	} fifo_phase_e;

	// Arbiter phases
	typedef enum logic [1:0] {
		idle_st,
		burst_st,
		gap_st
	} arb_phase_e;

endpackage

// >>> verilog/video_dma_if.sv
// Link between the video FIFO device and the bus arbiter
`timescale 1ns/1ps
interface video_dma_if;
	logic        register_write_strobe_n; // One-cycle register write strobe
	logic        video_dma_request_n;     // Pending need for video words
	logic        video_dma_ack_n;         // One word per low cycle
	logic [31:0] bus_data;                // Register or DMA data word

	// Documented device end
	modport device
	(
		input  register_write_strobe_n,
		input  video_dma_ack_n,
		input  bus_data,
		output video_dma_request_n
	);

	// Arbiter and memory controller end
	modport arbiter
	(
		output register_write_strobe_n,
		output video_dma_ack_n,
		output bus_data,
		input  video_dma_request_n
	);
endinterface // video_dma_if

// >>> verilog/video_fifo_device.sv
// Video FIFO with preload, refill and end-of-raster request control
`timescale 1ns/1ps
`include "video_fifo_map.svh"
module video_fifo_device #(
	parameter int DEPTH = 32 // Words held
)(
	input  wire logic              clk_in,            // Bus clock
	input  wire logic              rst_b_in,          // Async reset, low active
	input  wire logic              clk_en_in,         // Freezes all state when low
	video_dma_if.device            bus,               // Arbiter side
	input  wire logic              vflyback_in,       // Vertical flyback level
	input  wire logic              frame_start_in,    // Frame start pulse
	input  wire logic              hsync_in,          // Line sync pulse
	input  wire logic              pixel_pop_in,      // Display takes one word
	output logic            [31:0] pixel_data_out,    // Popped word
	output logic                   pixel_valid_out,   // Popped word valid pulse
	output logic [$clog2(DEPTH):0] fifo_level_out,    // Words held
	output logic                   inhibit_out,       // End-of-raster inhibit active
	output logic             [2:0] preload_out,       // Preload field as stored
	output logic             [3:0] data_test_out      // Test nibble as stored
);
	localparam int AW = $clog2(DEPTH); // Pointer width
	localparam int CW = AW + 1;        // Level width

	// Depth must hold the largest preload plus a full quad burst
	generate
		if (DEPTH < 32 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_depth_check
			$error("video_fifo_device: DEPTH must be a power of two, at least 32");
		end
	endgenerate

	// Whole state of the block
	typedef struct packed {
		video_fifo_pkg::fifo_phase_e phase;     // Request phase
		logic [DEPTH-1:0][31:0]      mem;       // Word storage
		logic [AW-1:0]               wr_ptr;    // Next write slot
		logic [AW-1:0]               rd_ptr;    // Next read slot
		logic [CW-1:0]               level;     // Words held
		logic [2:0]                  preload;   // Preload field
		logic [10:0]                 hwidth;    // Raster width in words
		logic                        hdis;      // Inhibit disable
		logic [3:0]                  dtest;     // Test nibble
		logic [11:0]                 fetched;   // Words fetched this raster
		logic [31:0]                 pix_data;  // Output word
		logic                        pix_valid; // Output strobe
	} dev_state_s;

	dev_state_s st_ff;  // Registered state
	dev_state_s nxt_st; // Next state

	logic          push;         // Word arriving
	logic          pop;          // Word leaving
	logic [2:0]    preload_code; // Preload field, zero read as one
	logic [CW-1:0] preload_lvl;  // Preload in words
	logic          inhibit;      // End-of-raster suppression
	logic          req;          // Request, high active

	// Preload level is four times the preload code
	always_comb
	begin
		preload_code = (st_ff.preload == 3'h0) ? 3'h1 : st_ff.preload;
		preload_lvl = CW'({preload_code, 2'b00});
	end

	// Suppress near raster end once enough words came in
	always_comb
	begin
		inhibit = !st_ff.hdis && (st_ff.fetched >= {1'b0, st_ff.hwidth});
	end

	// Request decision, from the level kept in this clock domain
	always_comb
	begin
		case (st_ff.phase)
			video_fifo_pkg::flush_st:   req = 1'b0;
			video_fifo_pkg::preload_st: req = (st_ff.level < preload_lvl);
			video_fifo_pkg::run_st:     req = (st_ff.level < preload_lvl) && !inhibit;
			default:                    req = 1'b0;
		endcase
	end

	// Request is combinational so a completed burst is seen at once
	assign bus.video_dma_request_n = ~req;

	// Push and pop qualifiers
	always_comb
	begin
		// Longer bursts are taken while room remains
		push = !bus.video_dma_ack_n && (st_ff.level != CW'(DEPTH)) && !vflyback_in;
		pop = pixel_pop_in && (st_ff.level != '0) && !vflyback_in;
	end

	// Next-state logic
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.pix_valid = 1'b0;

		// Register write: select from data, not address
		if (!bus.register_write_strobe_n)
		begin
			case (bus.bus_data[`SEL_MSB:`SEL_LSB])
				`SEL_CONTROL:
				begin
					nxt_st.preload = bus.bus_data[`PRELOAD_MSB:`PRELOAD_LSB];
				end
				`SEL_DATA_CTRL:
				begin
					nxt_st.hwidth = bus.bus_data[`HWIDTH_MSB:`HWIDTH_LSB];
					nxt_st.hdis = bus.bus_data[`HDIS_BIT];
					// Stored only; software keeps 0001 here
					nxt_st.dtest = bus.bus_data[`DTEST_MSB:`DTEST_LSB];
				end
				default:
				begin
					// Other macrocell registers live elsewhere
				end
			endcase
		end

		// Storage and level
		if (push)
		begin
			nxt_st.mem[st_ff.wr_ptr] = bus.bus_data;
			nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
		end
		if (pop)
		begin
			nxt_st.pix_data = st_ff.mem[st_ff.rd_ptr];
			nxt_st.pix_valid = 1'b1;
			nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
		end
		case ({push, pop})
			2'b10:   nxt_st.level = st_ff.level + 1'b1;
			2'b01:   nxt_st.level = st_ff.level - 1'b1;
			default: nxt_st.level = st_ff.level;
		endcase

		// Raster fetch count; a word arriving on the sync edge counts for the new raster
		if (hsync_in || frame_start_in)
		begin
			nxt_st.fetched = push ? 12'h001 : 12'h000;
		end
		else if (push && st_ff.fetched != 12'hfff)
		begin
			nxt_st.fetched = st_ff.fetched + 1'b1;
		end

		// Phase sequencing
		case (st_ff.phase)
			video_fifo_pkg::flush_st:
			begin
				if (frame_start_in && !vflyback_in)
				begin
					nxt_st.phase = video_fifo_pkg::preload_st;
				end
			end
			video_fifo_pkg::preload_st:
			begin
				if (st_ff.level >= preload_lvl)
				begin
					nxt_st.phase = video_fifo_pkg::run_st;
				end
			end
			video_fifo_pkg::run_st:
			begin
				// Stay until flyback
			end
			default:
			begin
				nxt_st.phase = video_fifo_pkg::flush_st;
			end
		endcase

		// Flyback empties the FIFO and waits for the next frame
		if (vflyback_in)
		begin
			nxt_st.phase = video_fifo_pkg::flush_st;
			nxt_st.wr_ptr = '0;
			nxt_st.rd_ptr = '0;
			nxt_st.level = '0;
		end
	end

	// State register; storage reset keeps the struct one register
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			st_ff <= '0;
			st_ff.phase <= video_fifo_pkg::flush_st;
			st_ff.preload <= `PRELOAD_RESET;
			st_ff.hwidth <= `HWIDTH_RESET;
		end
		else if (clk_en_in)
		begin
			st_ff <= nxt_st;
		end
	end

	// User outputs from flops, except inhibit_out, which is decoded from them
	assign pixel_data_out = st_ff.pix_data;
	assign pixel_valid_out = st_ff.pix_valid;
	assign fifo_level_out = st_ff.level;
	assign inhibit_out = inhibit;
	assign preload_out = st_ff.preload;
	assign data_test_out = st_ff.dtest;

endmodule // video_fifo_device

// >>> verilog/video_dma_arbiter.sv
// Bus arbiter end: register write decode and video DMA bursts
`timescale 1ns/1ps
`include "video_fifo_map.svh"
module video_dma_arbiter #(
	parameter int BURST_WORDS = 4 // Words per burst, multiple of four
)(
	input  wire logic        clk_in,          // Bus clock
	input  wire logic        rst_b_in,        // Async reset, low active
	input  wire logic        clk_en_in,       // Freezes all state when low
	video_dma_if.arbiter     bus,             // Device side
	input  wire logic        cpu_wr_valid_in, // CPU write request
	input  wire logic [31:0] cpu_wr_addr_in,  // CPU write address
	input  wire logic [31:0] cpu_wr_data_in,  // CPU write data
	output logic             cpu_wr_ready_out,// CPU write taken this cycle
	input  wire logic        dma_restart_in,  // Reload DMA pointer
	input  wire logic [29:0] dma_base_in,     // Word address to reload
	output logic      [29:0] mem_addr_out,    // Word address read now
	input  wire logic [31:0] mem_data_in      // Memory word at mem_addr_out
);
	// Bursts must be whole quads
	generate
		if (BURST_WORDS < `QUAD_WORDS || (BURST_WORDS % `QUAD_WORDS) != 0)
		begin : g_burst_check
			$error("video_dma_arbiter: BURST_WORDS must be a multiple of four");
		end
	endgenerate

	localparam int BW = $clog2(BURST_WORDS); // Beat counter width

	// Whole state of the arbiter
	typedef struct packed {
		video_fifo_pkg::arb_phase_e phase;    // Arbiter phase
		logic [BW-1:0]              beat;     // Beats issued
		logic [29:0]                addr;     // DMA word address
		logic                       strobe_n; // Register write strobe
		logic                       ack_n;    // DMA word strobe
		logic [31:0]                data;     // Bus data
	} arb_state_s;

	arb_state_s st_ff;  // Registered state
	arb_state_s nxt_st; // Next state

	logic in_window; // Address inside the macrocell window

	// Window decode made outside the device
	always_comb
	begin
		in_window = (cpu_wr_addr_in >= `REG_WIN_BASE) && (cpu_wr_addr_in <= `REG_WIN_LIMIT);
	end

	// CPU writes win only when idle; a burst is never split
	assign cpu_wr_ready_out = (st_ff.phase == video_fifo_pkg::idle_st);

	// Next-state logic
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.strobe_n = 1'b1;
		nxt_st.ack_n = 1'b1;
		case (st_ff.phase)
			video_fifo_pkg::idle_st:
			begin
				if (cpu_wr_valid_in)
				begin
					// Out-of-window writes are taken and dropped
					if (in_window)
					begin
						nxt_st.strobe_n = 1'b0;
						nxt_st.data = cpu_wr_data_in;
					end
				end
				else if (!bus.video_dma_request_n)
				begin
					nxt_st.phase = video_fifo_pkg::burst_st;
					nxt_st.beat = '0;
				end
			end
			video_fifo_pkg::burst_st:
			begin
				// One word per cycle, whole burst regardless of request
				nxt_st.ack_n = 1'b0;
				nxt_st.data = mem_data_in;
				nxt_st.addr = st_ff.addr + 1'b1;
				nxt_st.beat = st_ff.beat + 1'b1;
				if (st_ff.beat == BW'(BURST_WORDS - 1))
				begin
					nxt_st.phase = video_fifo_pkg::gap_st;
				end
			end
			video_fifo_pkg::gap_st:
			begin
				// Lets the last word reach the level before request is looked at again
				nxt_st.phase = video_fifo_pkg::idle_st;
			end
			default:
			begin
				nxt_st.phase = video_fifo_pkg::idle_st;
			end
		endcase
		// Pointer reload; software keeps the base quad aligned
		if (dma_restart_in && st_ff.phase != video_fifo_pkg::burst_st)
		begin
			nxt_st.addr = dma_base_in;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			st_ff <= '0;
			st_ff.phase <= video_fifo_pkg::idle_st;
			st_ff.strobe_n <= 1'b1;
			st_ff.ack_n <= 1'b1;
		end
		else if (clk_en_in)
		begin
			st_ff <= nxt_st;
		end
	end

	// Link and memory outputs, all from flops
	assign bus.register_write_strobe_n = st_ff.strobe_n;
	assign bus.video_dma_ack_n = st_ff.ack_n;
	assign bus.bus_data = st_ff.data;
	assign mem_addr_out = st_ff.addr;

endmodule // video_dma_arbiter

// >>> verification/video_fifo_dma_request_properties.sv
// Checks on the video DMA link between device and arbiter
`timescale 1ns/1ps
module video_fifo_dma_request_properties
(
	input wire logic        clk_in,                     // Bus clock
	input wire logic        rst_b_in,                   // Async reset, low active
	input wire logic        register_write_strobe_n_in, // Register write strobe
	input wire logic        video_dma_request_n_in,     // Device request
	input wire logic        video_dma_ack_n_in,         // Arbiter word strobe
	input wire logic [31:0] bus_data_in                 // Shared data word
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// Four beats, then the acknowledge lets go
	chk_burst_four_beats: assert property ($fell(video_dma_ack_n_in) |->
		!video_dma_ack_n_in [*4] ##1 video_dma_ack_n_in)
		else $error("burst not four beats");
	// A burst ends four samples after the acknowledge fell
	chk_burst_whole: assert property ($rose(video_dma_ack_n_in) |->
		$past(video_dma_ack_n_in, 5) && !$past(video_dma_ack_n_in, 4))
		else $error("burst length broken");
	// Idle cycle and first burst cycle before the next beat
	chk_burst_spacing: assert property ($rose(video_dma_ack_n_in) |-> video_dma_ack_n_in [*2])
		else $error("bursts too close");
	// Request checked two samples before the first beat, at the edge that took the burst
	chk_ack_on_request: assert property ($fell(video_dma_ack_n_in) |-> !$past(video_dma_request_n_in, 2))
		else $error("burst without request");
	// Request served promptly, or withdrawn
	chk_prompt_service: assert property ($fell(video_dma_request_n_in) |->
		##[1:10] (!video_dma_ack_n_in || video_dma_request_n_in))
		else $error("request not served");
	// Shared data bus carries one kind of word at a time
	chk_write_outside_burst: assert property (!video_dma_ack_n_in |-> register_write_strobe_n_in)
		else $error("strobe during burst");
	// Arbiter busy through burst and gap
	chk_strobe_quiet_burst: assert property ($fell(video_dma_ack_n_in) |-> register_write_strobe_n_in [*5])
		else $error("strobe too soon after burst");
	// Bench memory never repeats a word, so each beat is new
	chk_beat_new_word: assert property (!video_dma_ack_n_in && !$past(video_dma_ack_n_in) |->
		bus_data_in != $past(bus_data_in))
		else $error("beat repeated word");
	cover property (!register_write_strobe_n_in && bus_data_in[31:28] == 4'hf);
endmodule // video_fifo_dma_request_properties

// >>> verification/video_fifo_dma_request_tb_top.sv
// Bench joining the video FIFO device to the arbiter
`timescale 1ns/1ps
module video_fifo_dma_request_tb_top;
	logic        clk_in = 1'b0;     // Bus clock
	logic        rst_b_in = 1'b0;   // Reset, low
	logic        vfly = 1'b1;       // Flyback level
	logic        fstart = 1'b0;     // Frame start pulse
	logic        hsync = 1'b0;      // Line sync pulse
	logic        pop = 1'b0;        // Display pop
	logic        wr_valid = 1'b0;   // CPU write request
	logic [31:0] wr_addr = 32'h0;   // CPU write address
	logic [31:0] wr_data = 32'h0;   // CPU write word
	logic        restart = 1'b0;    // Pointer reload
	logic        clk_en = 1'b1;     // Shared clock enable
	logic [29:0] base = 30'h0;      // Frame buffer start
	logic [29:0] mem_addr;          // Word being read
	logic        wr_ready;          // Write taken
	logic [31:0] pix_data;          // Popped word
	logic        pix_valid;         // Popped word valid
	logic  [5:0] level;             // Words held
	logic        inhibit;           // Raster end inhibit
	logic  [2:0] preload;           // Stored preload code
	logic  [3:0] dtest;             // Stored test nibble
	logic [31:0] seed = 32'h1cdd;   // Xorshift state
	logic [31:0] got_q[$];          // Words seen at display side
	int          mismatches = 0;    // Failed compares
	int          n_compared = 0;    // All compares
	int          cycles = 0;        // Hang guard
	video_dma_if bus_if();
	// Both ends share one clock enable, so a freeze keeps them in step
	video_fifo_device i_video_fifo_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en), .bus(bus_if),
		.vflyback_in(vfly), .frame_start_in(fstart), .hsync_in(hsync), .pixel_pop_in(pop), .pixel_data_out(pix_data),
		.pixel_valid_out(pix_valid), .fifo_level_out(level), .inhibit_out(inhibit), .preload_out(preload),
		.data_test_out(dtest));
	video_dma_arbiter i_video_dma_arbiter (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en), .bus(bus_if),
		.cpu_wr_valid_in(wr_valid), .cpu_wr_addr_in(wr_addr), .cpu_wr_data_in(wr_data), .cpu_wr_ready_out(wr_ready),
		.dma_restart_in(restart), .dma_base_in(base), .mem_addr_out(mem_addr), .mem_data_in(word_at(mem_addr)));
	video_fifo_dma_request_properties i_props (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.register_write_strobe_n_in(bus_if.register_write_strobe_n),
		.video_dma_request_n_in(bus_if.video_dma_request_n),
		.video_dma_ack_n_in(bus_if.video_dma_ack_n), .bus_data_in(bus_if.bus_data));

	// Free-running clock
	always #12.5 clk_in = ~clk_in;
	// Collect display words mid-cycle, where the valid pulse has settled; also cut a hang short
	always @(negedge clk_in)
	begin
		cycles++;
		if (pix_valid === 1'b1)
			got_q.push_back(pix_data);
		if (cycles == 20000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Memory contents: unique per address
	function automatic logic [31:0] word_at(input logic [29:0] a);
		return {a, 2'h0} ^ 32'h5a5a0f0f;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Request held until taken at a ready edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk_in);
		wr_valid = 1'b1;
		wr_addr = a;
		wr_data = d;
		// Ready is settled mid-cycle; the next rising edge takes the write
		while (wr_ready !== 1'b1)
			@(negedge clk_in);
		@(negedge clk_in);
		wr_valid = 1'b0;
	endtask
	// Spaced pops so each valid pulse is seen alone
	task automatic pop_words(input int k);
		repeat (k)
		begin
			tick(1);
			pop = 1'b1;
			tick(1);
			pop = 1'b0;
		end
	endtask
	// One frame with a given preload code and inhibit-disable
	task automatic frame(input logic [2:0] code, input logic hdis);
		int          pre;
		int          k;
		logic [31:0] r;
		pre = (code == 3'h0) ? 4 : 4 * code;
		vfly = 1'b1;
		tick(12);
		chk("flushed level", 0, level);
		wr(32'h03400000 | (rnd() & 32'h000ffffc), {4'he, 17'h0, code, 8'h0});
		wr(32'h034ffffc, {4'hf, 8'h0, 4'h1, 2'h0, hdis, 2'h0, 11'(pre)});
		tick(2);
		chk("preload", code, preload);
		chk("test nibble", 1, dtest);
		r = rnd();
		base = {r[29:2], 2'h0};
		restart = 1'b1;
		tick(1);
		restart = 1'b0;
		vfly = 1'b0;
		fstart = 1'b1;
		tick(1);
		fstart = 1'b0;
		got_q.delete();
		k = 0;
		while (level < 6'(pre) && k < 400)
		begin
			tick(1);
			k++;
		end
		tick(12);
		chk("preload level", pre, level);
		// Enable low: a pop must leave the level alone
		clk_en = 1'b0;
		pop_words(1);
		chk("frozen level", pre, level);
		clk_en = 1'b1;
		chk("inhibit", !hdis, inhibit);
		pop_words(1);
		tick(12);
		chk("level after pop", hdis ? pre + 3 : pre - 1, level);
		chk("request_n", 1, bus_if.video_dma_request_n);
		hsync = 1'b1;
		tick(1);
		hsync = 1'b0;
		tick(12);
		chk("level after sync", pre + 3, level);
		k = 1 + int'(rnd() % 32'(pre));
		pop_words(k);
		tick(4);
		chk("pops seen", k + 1, got_q.size());
		foreach (got_q[i])
			chk("word", word_at(base + 30'(i)), got_q[i]);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Reset, refused writes, then every preload code
	initial
	begin
		tick(16);
		rst_b_in = 1'b1;
		tick(2);
		chk("request_n", 1, bus_if.video_dma_request_n);
		chk("preload", 1, preload);
		wr(32'h03500000, 32'he0000300);
		wr(32'h03400000, 32'hd0000300);
		tick(2);
		chk("preload", 1, preload);
		for (int n = 0; n < 8; n++)
			frame(3'(n), n[0]);
		// Dual panel: width holds two rasters of words, so the full preload leaves no inhibit
		vfly = 1'b1;
		tick(12);
		wr(32'h03400000, {4'hf, 8'h0, 4'h1, 2'h0, 1'b0, 2'h0, 11'(2 * 28)});
		vfly = 1'b0;
		fstart = 1'b1;
		tick(1);
		fstart = 1'b0;
		tick(100);
		chk("dual level", 28, level);
		chk("dual inhibit", 0, inhibit);
		end_of_test();
	end
endmodule // video_fifo_dma_request_tb_top
